//--- inc/status_link_defs.svh
`ifndef STATUS_LINK_DEFS_SVH
`define STATUS_LINK_DEFS_SVH

// ----------------------------------------------------------------
// register map (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define REG_CTRL_ADDR 8'h00
`define REG_PACKET_ADDR 8'h04
`define REG_IRQ_STAT_ADDR 8'h08
`define REG_IRQ_MASK_ADDR 8'h0C
`define REG_EVENT_ADDR 8'h10
`define REG_STATE_ADDR 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_ENABLE_BIT 0
`define IRQ_SENT_BIT 0
`define IRQ_DROP_BIT 1
`define IRQ_WIDTH 2

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define CTRL_RESET 1'b1
`define INTERVAL_NS 5000
`define CLK_PERIOD_NS 5
`define INTERVAL_CYCLES (`INTERVAL_NS / `CLK_PERIOD_NS)
`define START_MARK_CYCLES 4'h2

`endif

//--- inc/status_link_pkg.sv
package status_link_pkg;

    // ----------------------------------------------------------------
    // transmitter states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_END
    } tx_state_t;

endpackage : status_link_pkg

//--- hw/event_sync.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// three-stage synchroniser for a vector of asynchronous event inputs;
// a change counts once the second and third stages agree
// ----------------------------------------------------------------
module event_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] level_o
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    // shift chain; stage one feeds only stage two
    always_comb begin
        state_next = state_reg;
        state_next.s1 = async_i;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (state_reg.s2[i] == state_reg.s3[i]) begin
                state_next.level[i] = state_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_o = state_reg.level;

endmodule : event_sync

//--- hw/status_link_tx.sv
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "status_link_defs.svh"

module status_link_tx
    import status_link_pkg::*;
#(
    parameter int PKT_WIDTH = 8,
    parameter int INTERVAL_CYCLES = `INTERVAL_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // cpu event pins, asynchronous
    input wire logic [PKT_WIDTH-1:0] cpu_event_i,
    // link and interrupt
    output logic cpu_status_serial_line_o,
    output logic irq_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam int CNT_W = $clog2(INTERVAL_CYCLES + 1);
    localparam int IDX_W = $clog2(PKT_WIDTH);

    typedef struct packed {
        tx_state_t st;
        logic [CNT_W-1:0] interval;
        logic expired;
        logic [3:0] mark_cnt;
        logic [IDX_W-1:0] bit_idx;
        logic [PKT_WIDTH-1:0] packet;
        logic [PKT_WIDTH-1:0] shift;
        // events seen while a packet is out
        logic [PKT_WIDTH-1:0] held;
        logic [PKT_WIDTH-1:0] ev_prev;
        logic line;
        logic enable;
        logic [`IRQ_WIDTH-1:0] irq_stat;
        logic [`IRQ_WIDTH-1:0] irq_mask;
        logic [31:0] rdata;
        logic ack;
        logic err;
    } tx_reg_t;

    tx_reg_t state_reg;
    tx_reg_t state_next;
    logic [PKT_WIDTH-1:0] ev_level;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    event_sync #(
        .WIDTH(PKT_WIDTH)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(cpu_event_i),
        .level_o(ev_level)
    );

    // ----------------------------------------------------------------
    // interval divider strobe
    // ----------------------------------------------------------------
    // one-cycle enable at the end of each count; the divider keeps
    // running during a packet and the expiry is latched until used
    logic interval_wrap;

    assign interval_wrap =
        (state_reg.interval == CNT_W'(INTERVAL_CYCLES - 1));

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    logic [PKT_WIDTH-1:0] ev_rise;
    logic bus_req;
    logic [`IRQ_WIDTH-1:0] irq_set;
    logic [7:0] wb_word_adr;
    logic packet_done;
    // events go to the live register rather than to held
    logic capture_live;

    always_comb begin
        state_next = state_reg;
        ev_rise = ev_level & ~state_reg.ev_prev;
        irq_set = '0;
        packet_done = 1'b0;
        capture_live = 1'b0;
        // a strobe still high in the ack cycle is not a new request
        bus_req = wb_cyc_i && wb_stb_i && !state_reg.ack && !state_reg.err;
        // word aligned decode, low address bits ignored
        wb_word_adr = {wb_adr_i[7:2], 2'b00};
        // edge detector history follows the synchronised levels
        state_next.ev_prev = ev_level;
        // bus answers are one-cycle pulses unless set below
        state_next.ack = 1'b0;
        state_next.err = 1'b0;

        // ------------------------------------------------------------
        // interval counter runs from the module clock, restarted when a packet starts
        // ------------------------------------------------------------
        if (interval_wrap) begin
            state_next.interval = '0;
            state_next.expired = 1'b1;
        end else begin
            state_next.interval = state_reg.interval + 1'b1;
        end

        // ------------------------------------------------------------
        // transmitter sequence
        // ------------------------------------------------------------
        case (state_reg.st)
            TX_IDLE: begin
                state_next.line = 1'b0;
                // an expiry with nothing to send waits for an event
                if (state_reg.expired && |state_reg.packet &&
                        state_reg.enable) begin
                    state_next.st = TX_START;
                    state_next.line = 1'b1;
                    state_next.mark_cnt = 4'h1;
                    state_next.expired = 1'b0;
                    state_next.interval = '0;
                end
            end
            TX_START: begin
                // the line stays high for the whole mark count
                if (state_reg.mark_cnt == `START_MARK_CYCLES) begin
                    // snapshot; the live register stays frozen until the
                    // end marker so its sticky bits remain readable
                    state_next.shift = state_reg.packet;
                    state_next.st = TX_DATA;
                    state_next.bit_idx = IDX_W'(PKT_WIDTH - 1);
                    state_next.line = state_reg.packet[PKT_WIDTH-1];
                end else begin
                    state_next.mark_cnt = state_reg.mark_cnt + 4'h1;
                end
            end
            TX_DATA: begin
                // last data bit out, the end marker follows
                if (state_reg.bit_idx == '0) begin
                    state_next.st = TX_END;
                    state_next.line = 1'b1;
                end else begin
                    state_next.bit_idx = state_reg.bit_idx - 1'b1;
                    // msb first, one bit per clock
                    state_next.line =
                        state_reg.shift[state_reg.bit_idx - 1'b1];
                end
            end
            TX_END: begin
                state_next.st = TX_IDLE;
                state_next.line = 1'b0;
                state_next.shift = '0;
                // reload from held so nothing seen in flight is lost
                state_next.packet = state_reg.held;
                state_next.held = '0;
                packet_done = 1'b1;
            end
            default: begin
                // unreachable encodings fall back to idle
                state_next.st = TX_IDLE;
                state_next.line = 1'b0;
            end
        endcase

        // ------------------------------------------------------------
        // event capture, last so an event in the clearing cycle survives
        // ------------------------------------------------------------
        // idle or reloading: events join the live register; while a
        // packet is out they wait in held for the next one
        capture_live = (state_reg.st == TX_IDLE) || packet_done;
        for (int i = 0; i < PKT_WIDTH; i++) begin
            if (ev_rise[i] && capture_live) begin
                if (state_next.packet[i]) begin
                    irq_set[`IRQ_DROP_BIT] = 1'b1;
                end
                state_next.packet[i] = 1'b1;
            end else if (ev_rise[i]) begin
                if (state_reg.held[i]) begin
                    irq_set[`IRQ_DROP_BIT] = 1'b1;
                end
                state_next.held[i] = 1'b1;
            end
        end
        // a finished packet raises the sent flag
        if (packet_done) begin
            irq_set[`IRQ_SENT_BIT] = 1'b1;
        end

        // ------------------------------------------------------------
        // register bus, answers one cycle after the request
        // ------------------------------------------------------------
        if (bus_req) begin
            state_next.ack = 1'b1;
            state_next.rdata = '0;
            case (wb_word_adr)
                `REG_CTRL_ADDR: begin
                    // enable gates new packets, one in flight finishes
                    state_next.rdata[`CTRL_ENABLE_BIT] = state_reg.enable;
                    if (wb_we_i && wb_sel_i[0]) begin
                        state_next.enable = wb_dat_i[`CTRL_ENABLE_BIT];
                    end
                end
                `REG_PACKET_ADDR: begin
                    // live accumulator, frozen while a packet is out
                    state_next.rdata[PKT_WIDTH-1:0] = state_reg.packet;
                end
                `REG_IRQ_STAT_ADDR: begin
                    // write one to clear; a same-cycle set wins below
                    state_next.rdata[`IRQ_WIDTH-1:0] = state_reg.irq_stat;
                    if (wb_we_i && wb_sel_i[0]) begin
                        state_next.irq_stat = state_reg.irq_stat &
                            ~wb_dat_i[`IRQ_WIDTH-1:0];
                    end
                end
                `REG_IRQ_MASK_ADDR: begin
                    // mask gates only the output, status still records
                    state_next.rdata[`IRQ_WIDTH-1:0] = state_reg.irq_mask;
                    if (wb_we_i && wb_sel_i[0]) begin
                        state_next.irq_mask = wb_dat_i[`IRQ_WIDTH-1:0];
                    end
                end
                `REG_EVENT_ADDR: begin
                    // software may post events too, same sticky rules
                    if (wb_we_i && wb_sel_i[0] && capture_live) begin
                        state_next.packet = state_next.packet |
                            wb_dat_i[PKT_WIDTH-1:0];
                    end else if (wb_we_i && wb_sel_i[0]) begin
                        state_next.held = state_next.held |
                            wb_dat_i[PKT_WIDTH-1:0];
                    end
                end
                `REG_STATE_ADDR: begin
                    state_next.rdata[1:0] = state_reg.st;
                    state_next.rdata[2] = state_reg.line;
                    state_next.rdata[3] = state_reg.expired;
                    // events waiting for the following packet
                    state_next.rdata[16 +: PKT_WIDTH] = state_reg.held;
                end
                default: begin
                    state_next.ack = 1'b0;
                    state_next.err = 1'b1;
                end
            endcase
        end

        // ------------------------------------------------------------
        // set wins over a write-one clear in the same cycle
        // ------------------------------------------------------------
        state_next.irq_stat = state_next.irq_stat | irq_set;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // all clear except enable, which comes up set
            state_reg <= '0;
            state_reg.st <= TX_IDLE;
            state_reg.enable <= `CTRL_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign cpu_status_serial_line_o = state_reg.line;
    assign wb_dat_o = state_reg.rdata;
    assign wb_ack_o = state_reg.ack;
    assign wb_err_o = state_reg.err;
    // level interrupt from registered status and mask
    assign irq_o = |(state_reg.irq_stat & state_reg.irq_mask);

endmodule : status_link_tx

//--- tb/status_link_checker.sv
`timescale 1ns/1ps
// ------------------------------------------------
// link framing and bus handshake checker
// ------------------------------------------------
module status_link_checker #(
    parameter int PKT_WIDTH = 8,
    parameter int INTERVAL_CYCLES = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic [PKT_WIDTH-1:0] cpu_event_i,
    input wire logic cpu_status_serial_line_o,
    input wire logic irq_o
);
    logic [3:0] low_reg;
    logic [15:0] since_reg;
    logic frame;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // within a packet no zero run exceeds 7, so 8 quiet cycles mark a start
    assign frame = cpu_status_serial_line_o && low_reg >= 4'h8;
    // quiet-run and packet-spacing counters
    always_ff @(posedge clk_i) begin
        if (rst_i || cpu_status_serial_line_o) begin
            low_reg <= 4'h0;
        end else if (low_reg != 4'hF) begin
            low_reg <= low_reg + 4'h1;
        end
        if (rst_i) begin
            since_reg <= 16'h0;
        end else if (frame) begin
            since_reg <= 16'h1;
        end else if (since_reg != 16'hFFFF) begin
            since_reg <= since_reg + 16'h1;
        end
    end
    property p_frame;
        frame |=> cpu_status_serial_line_o ##9 cpu_status_serial_line_o
            ##1 !cpu_status_serial_line_o;
    endproperty
    a_frame: assert property (p_frame)
        else $error("start or end marker wrong");
    property p_gap;
        frame |-> ##11 !cpu_status_serial_line_o [*8];
    endproperty
    a_gap: assert property (p_gap)
        else $error("line not low after packet");
    property p_interval;
        frame |-> since_reg >= INTERVAL_CYCLES - 1;
    endproperty
    a_interval: assert property (p_interval)
        else $error("packets too close");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) // ack lasts one cycle
        else $error("ack longer than one cycle");
    property p_err_pulse;
        wb_err_o |=> !wb_err_o;
    endproperty
    a_err_pulse: assert property (p_err_pulse) // err lasts one cycle
        else $error("err longer than one cycle");
    property p_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o;
    endproperty
    a_answer: assert property (p_answer) // answer one cycle after request
        else $error("request not answered");
    property p_excl;
        !(wb_ack_o && wb_err_o);
    endproperty
    a_excl: assert property (p_excl) // never both answers
        else $error("ack and err together");
    property p_quiet;
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o;
    endproperty
    a_quiet: assert property (p_quiet) // no answer without request
        else $error("answer without request");
endmodule : status_link_checker

bind status_link_tx status_link_checker #(.PKT_WIDTH(PKT_WIDTH),
    .INTERVAL_CYCLES(INTERVAL_CYCLES)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .cpu_event_i(cpu_event_i), .irq_o(irq_o),
    .cpu_status_serial_line_o(cpu_status_serial_line_o));

//--- tb/status_rx_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// receiving power-management packet decoder
// ------------------------------------------------
module status_rx_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic line_i,
    input wire logic smi_en_i,
    output logic [7:0] pkt_o,
    output logic pkt_valid_o,
    output logic smi_o,
    output logic retrace_stat_o
);
    logic [3:0] cnt_reg;
    logic [7:0] sh_reg;
    // bit clock is the shared module clock; a bad end marker drops it
    always_ff @(posedge clk_i) begin
        pkt_valid_o <= 1'b0;
        smi_o <= 1'b0;
        if (rst_i) begin
            cnt_reg <= 4'h0;
            retrace_stat_o <= 1'b0;
        end else if (cnt_reg == 4'h0) begin
            cnt_reg <= {3'h0, line_i};
        end else if (cnt_reg == 4'h1) begin
            cnt_reg <= line_i ? 4'h2 : 4'h0;
        end else if (cnt_reg < 4'hA) begin
            sh_reg <= {sh_reg[6:0], line_i};
            cnt_reg <= cnt_reg + 4'h1;
        end else begin
            cnt_reg <= 4'h0;
            if (line_i) begin
                pkt_o <= sh_reg;
                pkt_valid_o <= 1'b1;
                if (sh_reg[7] && smi_en_i) begin
                    smi_o <= 1'b1;
                    retrace_stat_o <= 1'b1;
                end
            end
        end
    end
endmodule : status_rx_model

//--- tb/tb_status_link_tx.sv
`timescale 1ns/1ps
`include "status_link_defs.svh"
module tb_status_link_tx;
    logic clk_i, rst_i, we, cyc, stb, ack, err, line, irq, eb;
    logic valid, smi, rstat, smi_en;
    logic [7:0] adr, ev, pkt;
    logic [31:0] wdat, rdat, q;
    int n_errors, comparisons, i;
    status_link_tx #(.INTERVAL_CYCLES(20)) dut_u (.clk_i(clk_i),
        .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
        .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .cpu_event_i(ev),
        .cpu_status_serial_line_o(line), .irq_o(irq));
    status_rx_model rx_u (.clk_i(clk_i), .rst_i(rst_i), .line_i(line),
        .smi_en_i(smi_en), .pkt_o(pkt), .pkt_valid_o(valid), .smi_o(smi),
        .retrace_stat_o(rstat));
    task end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle, held until ack or err is sampled at an edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (ack === 1'b1 || err === 1'b1) break;
        end
        chk(i < 20, 1'b1);
        if (i == 20) end_sim();
        q = rdat;
        eb = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    // event levels must outlast the synchroniser in both phases
    task evp(input logic [7:0] m);
        @(posedge clk_i);
        ev <= m;
        repeat (6) @(posedge clk_i);
        ev <= 8'h00;
        repeat (6) @(posedge clk_i);
    endtask : evp
    task wait_pkt(input logic seen, input logic [7:0] exp);
        for (i = 0; i < 100; i++) begin
            @(posedge clk_i);
            #1;
            if (valid === 1'b1) break;
        end
        chk(i < 100, seen);
        if (seen && i < 100) chk(pkt, exp);
        if (seen && i == 100) end_sim();
    endtask : wait_pkt
    task t_reset;
        chk(line, 1'b0);
        rd(`REG_CTRL_ADDR, 32'h1);
        rd(`REG_IRQ_MASK_ADDR, 32'h0);
        rd(`REG_PACKET_ADDR, 32'h0);
        bus(1'b0, 8'h18, 32'h0);
        chk(eb, 1'b1);
    endtask : t_reset
    task t_accum;
        bus(1'b1, `REG_CTRL_ADDR, 32'h0);
        evp(8'h01);
        evp(8'h20);
        evp(8'h01);
        bus(1'b1, `REG_EVENT_ADDR, 32'h80);
        rd(`REG_PACKET_ADDR, 32'hA1);
        rd(`REG_IRQ_STAT_ADDR, 32'h2);
        wait_pkt(1'b0, 8'h00);
        bus(1'b1, `REG_CTRL_ADDR, 32'h1);
        wait_pkt(1'b1, 8'hA1);
        chk(smi, 1'b1);
        chk(rstat, 1'b1);
        rd(`REG_PACKET_ADDR, 32'h0);
        rd(`REG_IRQ_STAT_ADDR, 32'h3);
        bus(1'b1, `REG_IRQ_MASK_ADDR, 32'h1);
        chk(irq, 1'b1);
        bus(1'b1, `REG_IRQ_STAT_ADDR, 32'h3);
        chk(irq, 1'b0);
        rd(`REG_IRQ_STAT_ADDR, 32'h0);
    endtask : t_accum
    // an event raised in mid-shift must reach the following packet
    task t_during;
        bus(1'b1, `REG_EVENT_ADDR, 32'h2);
        for (i = 0; i < 60; i++) begin
            @(posedge clk_i);
            #1;
            if (line === 1'b1) break;
        end
        chk(i < 60, 1'b1);
        if (i == 60) end_sim();
        rd(`REG_PACKET_ADDR, 32'h2);
        @(posedge clk_i);
        ev <= 8'h08;
        wait_pkt(1'b1, 8'h02);
        chk(smi, 1'b0);
        @(posedge clk_i);
        ev <= 8'h00;
        wait_pkt(1'b1, 8'h08);
        wait_pkt(1'b0, 8'h00);
    endtask : t_during
    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // main sequence
    initial begin
        rst_i = 1'b1;
        {we, cyc, stb, adr, wdat, ev} = '0;
        smi_en = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_accum();
        t_during();
        end_sim();
    end
endmodule : tb_status_link_tx
